// *** verilog/lid_closure_recal_control.sv ***
// Lid closure detection, threshold broadcast and recalibration settings
// Function
// - Lid status bit sets after N consecutive above-threshold samples, N 1..8, default 2.
// - Queue length code zero means one sample.
// - Queue runs per sensor and governs both setting and clearing status.
// - Pattern matches only set the flag while lid detection is enabled; all-zero masks clear it even when disabled.
// - Two seven-bit pattern masks, sensors 1-7 and 8-14, reset all ones.
// - Compare-mode bit 1 of lid config picks exact or count comparison.
// - A detected lid closure sets the lid event flag.
// - Exact mode: event when every mask bit is set in lid status.
// - Count mode: event when set status bits 1-7 reach low mask count.
// - Count mode: event when set status bits 8-14 reach high mask count.
// - Count mode: event when total status bits reach total mask bits.
// - Both masks zero disables detection and clears the lid event flag.
// - Button broadcast bit 7 copies sensor-1 threshold writes to buttons 2-7.
// - Button thresholds 2-7 accept individual writes at any time.
// - Group broadcast bit 6 copies sensor-1 threshold writes to group threshold.
// - Negative delta field: 8, 16, 32 default, or disabled.
// - Calibration code sets averaged samples 16, 32, 64, else 256.
// - Calibration code sets base update interval 16 up to 7936 cycles.
// - Configured sample count is averaged before base count replacement.
// - Recalibration settings are common; per-sensor enables select participants.
// - Lid evaluation happens only when lid enable bit 7 is one.
// - Lid alert enable bit 0 drives alert on a lid event.
// - Sensor output above its lid threshold is a qualifying sample.
`default_nettype none
`include "lid_recal_regs.svh"

module lid_closure_recal_control (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic sampleValid,
  input wire logic [3:0] sampleIndex,
  input wire logic [7:0] sampleDelta,
  input wire logic [7:0] sampleLidThreshold,
  input wire logic cycleDone,
  input wire logic lidEventClear,
  input wire logic [13:0] recalEnable,
  output logic [13:0] lidStatus,
  output logic lidEventFlag,
  output logic alert,
  output logic [7:0][6:0] thresholds,
  output logic negDeltaEnable,
  output logic [5:0] negDeltaLimit,
  output logic [8:0] recalSamples,
  output logic [12:0] updateInterval,
  output logic [13:0] baseUpdate
);

  // Configuration registers
  logic [7:0] lidConfig_reg, lidConfig_next;
  logic [3:0] queueLen_reg, queueLen_next;
  lid_recal_pkg::pattern_t patternLow_reg, patternLow_next;
  lid_recal_pkg::pattern_t patternHigh_reg, patternHigh_next;
  logic [7:0] recalConfig_reg, recalConfig_next;
  logic [7:0][6:0] thresh_reg, thresh_next;
  logic [7:0] rdData_reg, rdData_next;

  logic lidEnable, compareMode, alertEnable, buttonBcast, groupBcast;
  logic writeFirst;

  assign lidEnable = lidConfig_reg[`BIT_LID_ENABLE];
  assign compareMode = lidConfig_reg[`BIT_COMPARE_MODE];
  assign alertEnable = lidConfig_reg[`BIT_ALERT_ENABLE];
  assign buttonBcast = recalConfig_reg[`BIT_BUTTON_BCAST];
  assign groupBcast = recalConfig_reg[`BIT_GROUP_BCAST];
  assign writeFirst = regWrite && (regAddr == `ADDR_THRESH_FIRST);

  // Register writes; broadcast copies ride on the sensor-1 write
  always_comb begin
    lidConfig_next = lidConfig_reg;
    queueLen_next = queueLen_reg;
    patternLow_next = patternLow_reg;
    patternHigh_next = patternHigh_reg;
    recalConfig_next = recalConfig_reg;
    thresh_next = thresh_reg;
    if (regWrite) begin
      case (regAddr)
        `ADDR_LID_CONFIG: lidConfig_next = regWrData;
        `ADDR_LID_QUEUE: queueLen_next = regWrData[3:0];
        `ADDR_PATTERN_LOW: patternLow_next = regWrData[6:0];
        `ADDR_PATTERN_HIGH: patternHigh_next = regWrData[6:0];
        `ADDR_RECAL_CONFIG: recalConfig_next = regWrData;
        default: begin
          // Each threshold takes its own write at any time
          if (regAddr >= `ADDR_THRESH_FIRST && regAddr <= `ADDR_THRESH_GROUP) begin
            thresh_next[3'(regAddr - `ADDR_THRESH_FIRST)] = regWrData[6:0];
          end
        end
      endcase
    end
    if (writeFirst && buttonBcast) begin
      for (int i = 1; i < `HALF_COUNT; i++) begin
        thresh_next[i] = regWrData[6:0];
      end
    end
    if (writeFirst && groupBcast) begin
      thresh_next[`GROUP_THRESH_INDEX] = regWrData[6:0];
    end
  end

  // Read data is captured so the bus sees a stable byte; unmapped reads give zero
  always_comb begin
    rdData_next = rdData_reg;
    if (regRead) begin
      case (regAddr)
        `ADDR_LID_CONFIG: rdData_next = lidConfig_reg;
        `ADDR_LID_QUEUE: rdData_next = {4'h0, queueLen_reg};
        `ADDR_PATTERN_LOW: rdData_next = {1'b0, patternLow_reg};
        `ADDR_PATTERN_HIGH: rdData_next = {1'b0, patternHigh_reg};
        `ADDR_RECAL_CONFIG: rdData_next = recalConfig_reg;
        default: begin
          rdData_next = 8'h00;
          if (regAddr >= `ADDR_THRESH_FIRST && regAddr <= `ADDR_THRESH_GROUP) begin
            rdData_next = {1'b0, thresh_reg[3'(regAddr - `ADDR_THRESH_FIRST)]};
          end
        end
      endcase
    end
  end

  // Defaults loaded on reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lidConfig_reg <= `RST_LID_CONFIG;
      queueLen_reg <= `RST_LID_QUEUE;
      patternLow_reg <= `RST_PATTERN;
      patternHigh_reg <= `RST_PATTERN;
      recalConfig_reg <= `RST_RECAL_CONFIG;
      thresh_reg <= {`THRESH_COUNT{`RST_THRESHOLD}};
      rdData_reg <= 8'h00;
    end else begin
      lidConfig_reg <= lidConfig_next;
      queueLen_reg <= queueLen_next;
      patternLow_reg <= patternLow_next;
      patternHigh_reg <= patternHigh_next;
      recalConfig_reg <= recalConfig_next;
      thresh_reg <= thresh_next;
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;
  assign thresholds = thresh_reg;

  // Queue length decode: zero acts as one, values past eight clamp
  logic [3:0] requiredCount;
  always_comb begin
    if (queueLen_reg == 4'h0) begin
      requiredCount = `QUEUE_MIN;
    end else if (queueLen_reg > `QUEUE_MAX) begin
      requiredCount = `QUEUE_MAX;
    end else begin
      requiredCount = queueLen_reg;
    end
  end

  // Qualifying sample: output strictly above its lid threshold
  logic sampleAbove;
  assign sampleAbove = sampleDelta > sampleLidThreshold;

  // One independent queue per sensor, buttons and grouped alike
  for (genvar s = 0; s < `SENSOR_COUNT; s++) begin : gen_queue
    lid_queue_filter u_queue (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .sampleStrobe(sampleValid && (sampleIndex == 4'(s))),
      .sampleAbove(sampleAbove),
      .requiredCount(requiredCount),
      .lidStatus(lidStatus[s])
    );
  end

  // Decision logic
  lid_recal_pkg::pattern_t statusLow, statusHigh;
  lid_recal_pkg::bit_count_t cntStatLow, cntStatHigh, cntPatLow, cntPatHigh;
  logic patternsZero, exactHit, countHit, eventHit;

  assign statusLow = lidStatus[6:0];
  assign statusHigh = lidStatus[13:7];
  assign cntStatLow = lid_recal_pkg::popcount7(statusLow);
  assign cntStatHigh = lid_recal_pkg::popcount7(statusHigh);
  assign cntPatLow = lid_recal_pkg::popcount7(patternLow_reg);
  assign cntPatHigh = lid_recal_pkg::popcount7(patternHigh_reg);
  assign patternsZero = (patternLow_reg == 7'h00) && (patternHigh_reg == 7'h00);
  assign exactHit = ((statusLow & patternLow_reg) == patternLow_reg)
                 && ((statusHigh & patternHigh_reg) == patternHigh_reg);
  assign countHit = (cntStatLow >= cntPatLow)
                 || (cntStatHigh >= cntPatHigh)
                 || ((4'(cntStatLow) + 4'(cntStatHigh))
                     >= (4'(cntPatLow) + 4'(cntPatHigh)));
  assign eventHit = compareMode ? exactHit : countHit;

  // Evaluation runs one cycle after the sampling cycle ends, once queues have settled
  lid_recal_pkg::eval_state_t state_reg, state_next;
  logic flag_reg, flag_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lid_recal_pkg::EVAL_IDLE: if (cycleDone) state_next = lid_recal_pkg::EVAL_RUN;
      lid_recal_pkg::EVAL_RUN: state_next = cycleDone ? lid_recal_pkg::EVAL_RUN
                                                      : lid_recal_pkg::EVAL_IDLE;
      default: state_next = lid_recal_pkg::EVAL_IDLE;
    endcase
  end

  // Sticky event flag; a detection in the clear cycle wins over the clear
  always_comb begin
    flag_next = flag_reg;
    if (lidEventClear) begin
      flag_next = 1'b0;
    end
    if (patternsZero) begin
      flag_next = 1'b0;
    end else if (state_reg == lid_recal_pkg::EVAL_RUN && lidEnable && eventHit) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= lid_recal_pkg::EVAL_IDLE;
      flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      flag_reg <= flag_next;
    end
  end

  assign lidEventFlag = flag_reg;
  assign alert = flag_reg && alertEnable;

  // Recalibration decode, common to all sensors
  logic [1:0] negCode;
  logic [2:0] calCode;
  assign negCode = recalConfig_reg[`NEG_DELTA_HI:`NEG_DELTA_LO];
  assign calCode = recalConfig_reg[`CAL_CFG_HI:`CAL_CFG_LO];
  assign negDeltaEnable = negCode != `NEG_DELTA_OFF;

  always_comb begin
    case (negCode)
      2'h0: negDeltaLimit = `NEG_DELTA_8;
      2'h1: negDeltaLimit = `NEG_DELTA_16;
      2'h2: negDeltaLimit = `NEG_DELTA_32;
      default: negDeltaLimit = 6'h00;
    endcase
    // Front end averages this many samples before replacing the base count
    case (calCode)
      3'h0: recalSamples = `SAMPLES_16;
      3'h1: recalSamples = `SAMPLES_32;
      3'h2: recalSamples = `SAMPLES_64;
      default: recalSamples = `SAMPLES_256;
    endcase
    case (calCode)
      3'h0: updateInterval = `INTERVAL_16;
      3'h1: updateInterval = `INTERVAL_32;
      3'h2: updateInterval = `INTERVAL_64;
      3'h3: updateInterval = `INTERVAL_256;
      3'h4: updateInterval = `INTERVAL_1024;
      3'h5: updateInterval = `INTERVAL_2048;
      3'h6: updateInterval = `INTERVAL_4096;
      default: updateInterval = `INTERVAL_7936;
    endcase
  end

  // Polling-cycle counter; shrinking the interval mid-count ends the period early
  logic [12:0] pollCount_reg, pollCount_next;
  logic [13:0] update_reg, update_next;

  always_comb begin
    pollCount_next = pollCount_reg;
    update_next = '0;
    if (cycleDone) begin
      if (13'(pollCount_reg + 13'h0001) >= updateInterval) begin
        pollCount_next = '0;
        update_next = recalEnable;
      end else begin
        pollCount_next = 13'(pollCount_reg + 13'h0001);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pollCount_reg <= '0;
      update_reg <= '0;
    end else begin
      pollCount_reg <= pollCount_next;
      update_reg <= update_next;
    end
  end

  assign baseUpdate = update_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic evalNow;
  assign evalNow = (state_reg == lid_recal_pkg::EVAL_RUN) && lidEnable && !patternsZero;

  chk_zero_pattern_clear: assert property (patternsZero |=> !lidEventFlag)
    else $error("lid event flag not cleared with zero patterns");
  chk_exact_match_sets: assert property (evalNow && compareMode && exactHit
      && !$changed(patternLow_reg) |=> lidEventFlag)
    else $error("exact pattern match did not set lid event");
  chk_count_low_sets: assert property (evalNow && !compareMode
      && cntStatLow >= cntPatLow |=> lidEventFlag || patternsZero)
    else $error("low half count did not set lid event");
  chk_count_high_sets: assert property (evalNow && !compareMode
      && cntStatHigh >= cntPatHigh |=> lidEventFlag || patternsZero)
    else $error("high half count did not set lid event");
  chk_count_total_sets: assert property (evalNow && !compareMode
      && (4'(cntStatLow) + 4'(cntStatHigh)) >= (4'(cntPatLow) + 4'(cntPatHigh))
      |=> lidEventFlag || patternsZero)
    else $error("total count did not set lid event");
  chk_disabled_no_set: assert property (!lidEnable && !lidEventFlag
      ##1 !lidEnable |-> !lidEventFlag)
    else $error("lid event set while detection disabled");
  chk_eval_after_done: assert property ($rose(lidEventFlag)
      |-> $past(state_reg == lid_recal_pkg::EVAL_RUN))
    else $error("lid event set outside an evaluation cycle");
  chk_alert_on_event: assert property ($rose(lidEventFlag) && alertEnable |-> alert)
    else $error("alert not raised on lid event");
  chk_button_bcast: assert property (writeFirst && buttonBcast
      |=> thresholds[6] == $past(regWrData[6:0]) && thresholds[1] == $past(regWrData[6:0]))
    else $error("button threshold broadcast missing");
  chk_group_hold: assert property (writeFirst && !groupBcast
      |=> $stable(thresholds[`GROUP_THRESH_INDEX]))
    else $error("group threshold changed without broadcast");
  chk_neg_delta_off: assert property (negCode == `NEG_DELTA_OFF |-> !negDeltaEnable
      && negDeltaLimit == 6'h00)
    else $error("negative delta trigger not disabled");

  cov_exact_event: cover property (compareMode ##1 $rose(lidEventFlag));
  cov_count_event: cover property (!compareMode ##1 $rose(lidEventFlag));
  cov_bcast_write: cover property (writeFirst && buttonBcast && groupBcast);
  cov_base_update: cover property (baseUpdate != 14'h0000);

endmodule
`default_nettype wire

// *** verilog/lid_recal_regs.svh ***
// Register offsets, field positions, reset values and decode constants for lid/recal control
`ifndef LID_RECAL_REGS_SVH
`define LID_RECAL_REGS_SVH

// Register offsets
`define ADDR_LID_CONFIG 8'h2b
`define ADDR_LID_QUEUE 8'h2c
`define ADDR_PATTERN_LOW 8'h2d
`define ADDR_PATTERN_HIGH 8'h2e
`define ADDR_RECAL_CONFIG 8'h2f
`define ADDR_THRESH_FIRST 8'h30
`define ADDR_THRESH_GROUP 8'h37

// Reset values
`define RST_LID_CONFIG 8'h00
`define RST_LID_QUEUE 4'h2
`define RST_PATTERN 7'h7f
`define RST_RECAL_CONFIG 8'h93
`define RST_THRESHOLD 7'h40

// Lid configuration bit positions
`define BIT_LID_ENABLE 7
`define BIT_COMPARE_MODE 1
`define BIT_ALERT_ENABLE 0

// Recalibration configuration fields
`define BIT_BUTTON_BCAST 7
`define BIT_GROUP_BCAST 6
`define NEG_DELTA_HI 4
`define NEG_DELTA_LO 3
`define CAL_CFG_HI 2
`define CAL_CFG_LO 0

// Queue length decode
`define QUEUE_MIN 4'h1
`define QUEUE_MAX 4'h8

// Negative delta decode
`define NEG_DELTA_8 6'h08
`define NEG_DELTA_16 6'h10
`define NEG_DELTA_32 6'h20
`define NEG_DELTA_OFF 2'h3

// Recalibration samples and base update interval decode
`define SAMPLES_16 9'h010
`define SAMPLES_32 9'h020
`define SAMPLES_64 9'h040
`define SAMPLES_256 9'h100
`define INTERVAL_16 13'h0010
`define INTERVAL_32 13'h0020
`define INTERVAL_64 13'h0040
`define INTERVAL_256 13'h0100
`define INTERVAL_1024 13'h0400
`define INTERVAL_2048 13'h0800
`define INTERVAL_4096 13'h1000
`define INTERVAL_7936 13'h1f00

// Sensor counts
`define SENSOR_COUNT 14
`define HALF_COUNT 7
`define THRESH_COUNT 8
`define GROUP_THRESH_INDEX 3'h7

`endif

// *** verilog/lid_recal_pkg.sv ***
// Types and helper functions for lid closure and recalibration control
`default_nettype none
package lid_recal_pkg;

  typedef enum logic {
    EVAL_IDLE,
    EVAL_RUN
  } eval_state_t;

  typedef logic [6:0] pattern_t;
  typedef logic [2:0] bit_count_t;

  // Number of set bits in a seven-bit half
  function automatic bit_count_t popcount7(input pattern_t value);
    bit_count_t total;
    total = '0;
    for (int i = 0; i < 7; i++) begin
      total = bit_count_t'(total + bit_count_t'(value[i]));
    end
    return total;
  endfunction

endpackage
`default_nettype wire

// *** verilog/lid_queue_filter.sv ***
// Per-sensor consecutive-sample queue that sets and clears one lid status bit
`default_nettype none
`include "lid_recal_regs.svh"

module lid_queue_filter (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sampleStrobe,
  input wire logic sampleAbove,
  input wire logic [3:0] requiredCount,
  output logic lidStatus
);

  logic status_reg;
  logic status_next;
  logic [3:0] run_reg;
  logic [3:0] run_next;

  // Count samples that disagree with the current status; flip after enough in a row
  always_comb begin
    status_next = status_reg;
    run_next = run_reg;
    if (sampleStrobe) begin
      if (sampleAbove == status_reg) begin
        run_next = '0;
      end else if (4'(run_reg + 4'h1) >= requiredCount) begin
        status_next = sampleAbove;
        run_next = '0;
      end else begin
        run_next = 4'(run_reg + 4'h1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= 1'b0;
      run_reg <= '0;
    end else begin
      status_reg <= status_next;
      run_reg <= run_next;
    end
  end

  assign lidStatus = status_reg;

endmodule
`default_nettype wire

// *** dv/lid_sensor_front.sv ***
// Behavioural sensor front end: one sample per sensor, then a cycle end pulse
`default_nettype none
module lid_sensor_front (
  input wire logic clk_sys,
  output logic sampleValid,
  output logic [3:0] sampleIndex,
  output logic [7:0] sampleDelta,
  output logic [7:0] sampleLidThreshold,
  output logic cycleDone
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels before the first frame
  initial begin
    sampleValid = 1'b0;
    sampleIndex = 4'h0;
    sampleDelta = 8'h5a;
    sampleLidThreshold = 8'ha5;
    cycleDone = 1'b0;
  end

  // Back-to-back samples; a delta equal to its threshold is not above it
  task automatic run(input logic [13:0] above, input logic [31:0] r);
    logic [7:0] t;
    for (int i = 0; i < 14; i++) begin
      @(negedge clk_sys);
      t = {1'b0, r[6:0]} | 8'h01;
      sampleValid = 1'b1;
      sampleIndex = 4'(i);
      sampleLidThreshold = t;
      sampleDelta = above[i] ? t + 8'h01 + {2'h0, r[13:8]} : t - {7'h0, r[8]};
      r = {r[30:0], r[31] ^ r[21]};
    end
    @(negedge clk_sys);
    sampleValid = 1'b0;
    sampleDelta = ~sampleDelta; // Released lines must not keep the last value
    sampleIndex = ~sampleIndex;
    cycleDone = 1'b1;
    @(negedge clk_sys);
    cycleDone = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/lid_closure_recal_control_test.sv ***
// Self-checking bench for lid closure detection and recalibration settings
`default_nettype none
module lid_closure_recal_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, regWrite, regRead, lidEventClear;
  logic [7:0] regAddr, regWrData, regRdData, sampleDelta, sampleLidThreshold;
  logic sampleValid, cycleDone, lidEventFlag, alert, negDeltaEnable;
  logic [3:0] sampleIndex;
  logic [13:0] recalEnable, lidStatus, baseUpdate, statM, ab;
  logic [7:0][6:0] thresholds, thrM;
  logic [5:0] negDeltaLimit;
  logic [8:0] recalSamples;
  logic [12:0] updateInterval;
  logic [31:0] lfsrState;
  logic [7:0] cfgM, recM, d;
  logic [3:0] qM;
  logic [6:0] patLo, patHi;
  logic flagM;
  int errors, cmp_count, pulses;
  int cntM[14];
  int iv[8] = '{16, 32, 64, 256, 1024, 2048, 4096, 7936};

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  lid_closure_recal_control DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sampleValid(sampleValid), .sampleIndex(sampleIndex), .sampleDelta(sampleDelta),
    .sampleLidThreshold(sampleLidThreshold), .cycleDone(cycleDone),
    .lidEventClear(lidEventClear), .recalEnable(recalEnable), .lidStatus(lidStatus),
    .lidEventFlag(lidEventFlag), .alert(alert), .thresholds(thresholds),
    .negDeltaEnable(negDeltaEnable), .negDeltaLimit(negDeltaLimit),
    .recalSamples(recalSamples), .updateInterval(updateInterval), .baseUpdate(baseUpdate)
  );

  lid_sensor_front front (
    .clk_sys(clk_sys), .sampleValid(sampleValid), .sampleIndex(sampleIndex),
    .sampleDelta(sampleDelta), .sampleLidThreshold(sampleLidThreshold),
    .cycleDone(cycleDone)
  );

  // Stimulus source: one step of a 32-bit shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic nxt();
    lfsrState = lfsr(lfsrState);
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One-cycle strobes; a spare cycle between requests
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk_sys);
    regRead = 1'b0;
    v = regRdData;
  endtask

  task automatic wm(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge clk_sys);
    regWrite = 1'b0;
    regWrData = ~v;
    case (a)
      8'h2b: cfgM = v;
      8'h2c: qM = v[3:0];
      8'h2d: patLo = v[6:0];
      8'h2e: patHi = v[6:0];
      8'h2f: recM = v;
      default: ;
    endcase
    if (a == 8'h30) begin
      thrM[0] = v[6:0];
      for (int i = 1; i < 7; i++)
        if (recM[7]) thrM[i] = v[6:0];
      if (recM[6]) thrM[7] = v[6:0];
    end else if (a > 8'h30 && a < 8'h38) begin
      thrM[a[2:0]] = v[6:0];
    end
    if (patLo == 7'h00 && patHi == 7'h00) flagM = 1'b0;
  endtask

  // Model one sampling cycle, run it through the front end, then compare
  task automatic cyc(input logic [13:0] above);
    int n, sl, sh, pl, ph;
    logic hit;
    n = (qM == 4'h0) ? 1 : (qM > 4'h8 ? 8 : int'(qM));
    for (int i = 0; i < 14; i++) begin
      cntM[i] = (above[i] == statM[i]) ? 0 : cntM[i] + 1;
      // A run already past a shortened queue flips on its next sample
      if (cntM[i] >= n) begin
        statM[i] = above[i];
        cntM[i] = 0;
      end
    end
    sl = $countones(statM[6:0]);
    sh = $countones(statM[13:7]);
    pl = $countones(patLo);
    ph = $countones(patHi);
    if (cfgM[1]) hit = ((statM[6:0] & patLo) == patLo)
                       && ((statM[13:7] & patHi) == patHi);
    else hit = sl >= pl || sh >= ph || sl + sh >= pl + ph;
    if (cfgM[7] && (pl + ph) > 0 && hit) flagM = 1'b1;
    nxt();
    front.run(above, lfsrState);
    repeat (2) @(negedge clk_sys);
    chk("lidStatus", 16'(lidStatus), 16'(statM));
    chk("lidEventFlag", 16'(lidEventFlag), 16'(flagM));
    chk("alert", 16'(alert), 16'(flagM & cfgM[0]));
  endtask

  task automatic clr();
    @(negedge clk_sys);
    lidEventClear = 1'b1;
    @(negedge clk_sys);
    lidEventClear = 1'b0;
    flagM = 1'b0;
    chk("lidEventFlag", 16'(lidEventFlag), 16'(flagM));
  endtask

  // Every base update pulse carries the per-sensor enables; looked at mid-cycle, once settled
  always @(negedge clk_sys) begin
    if (reset_n === 1'b1 && baseUpdate !== 14'h0) begin
      pulses++;
      chk("baseUpdate", 16'(baseUpdate), 16'(recalEnable));
    end
  end

  initial begin
    #200000;
    errors++;
    final_report();
  end

  initial begin
    lfsrState = 32'hd5f506c6;
    {regWrite, regRead, lidEventClear, reset_n} = 4'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    recalEnable = lfsrState[13:0] | 14'h0001;
    thrM = {8{7'h40}};
    statM = 14'h0;
    cntM = '{default: 0};
    {cfgM, qM, patLo, patHi, recM, flagM} = {8'h00, 4'h2, 7'h7f, 7'h7f, 8'h93, 1'b0};
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    // Reset values, including one unmapped place at the end
    for (int a = 8'h2b; a < 8'h39; a++) begin
      rd(8'(a), d);
      chk("rdData", 16'(d), a == 8'h2b ? 16'h00 : a == 8'h2c ? 16'h02 :
          a < 8'h2f ? 16'h7f : a == 8'h2f ? 16'h93 : a < 8'h38 ? 16'h40 : 16'h00);
    end
    wm(8'h2d, 8'hff);
    rd(8'h2d, d);
    chk("pattern", 16'(d), 16'h7f);
    // Shortest interval: two base updates in 32 cycles
    wm(8'h2f, 8'h90);
    repeat (32) cyc(14'h0);
    chk("pulses", 16'(pulses), 16'h2);
    for (int c = 0; c < 8; c++) begin
      wm(8'h2f, {3'h4, 2'(c), 3'(c)});
      chk("samples", 16'(recalSamples), c < 3 ? 16'(16 << c) : 16'd256);
      chk("interval", 16'(updateInterval), 16'(iv[c]));
      chk("ndLimit", 16'(negDeltaLimit), c % 4 == 3 ? 16'h0 : 16'(8 << (c % 4)));
      chk("ndEnable", 16'(negDeltaEnable), 16'(c % 4 != 3));
    end
    for (int k = 0; k < 4; k++) begin
      nxt();
      wm(8'h2f, {2'(k), 6'h13});
      wm(8'h30, lfsrState[7:0]);
      wm(8'h33, lfsrState[15:8]);
      if (k < 2) wm(8'h37, lfsrState[23:16]);
      for (int i = 0; i < 8; i++)
        chk("threshold", 16'(thresholds[i]), 16'(thrM[i]));
      rd(8'h37, d);
      chk("rdGroup", 16'(d), 16'(thrM[7]));
    end
    // Random queue, mode, enable and pattern settings
    for (int it = 0; it < 60; it++) begin
      cyc(statM);
      nxt();
      wm(8'h2c, {4'h0, lfsrState[3:0]});
      wm(8'h2b, {lfsrState[4] | lfsrState[5], 5'h0, lfsrState[6], lfsrState[7]});
      wm(8'h2d, lfsrState[18:16] == 3'h0 ? 8'h00 : lfsrState[15:8]);
      wm(8'h2e, lfsrState[18:16] == 3'h0 ? 8'h00 : lfsrState[27:20]);
      repeat (3) begin
        nxt();
        ab = lfsrState[13:0] | lfsrState[29:16];
        cyc(ab);
      end
      if (lfsrState[30]) clr();
    end
    final_report();
  end
endmodule
`default_nettype wire
